/* flsv_top.sv */
// Top of the fiber link sideband and verify block with its APB slave
//
// Added by the designer: the placing of the registers and the APB register port.
module flsv_top #(
   parameter int SEC_CYC = flsv_pkg::FLSV_SEC_CYC
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [11:0]           i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic      [31:0]           o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,
   output flsv_pkg::flsv_word_t       o_tx_word,
   output flsv_pkg::flsv_sideband_t   o_tx_sideband,
   input  wire flsv_pkg::flsv_word_t  i_rx_word,
   input  wire flsv_pkg::flsv_sideband_t i_rx_sideband,
   output logic                       o_int_loop,
   output logic                       o_check_busy
);
   import flsv_pkg::*;

   logic           wr_en;
   logic           rd_en;
   logic           addr_ok;
   flsv_state_t    st_reg;
   flsv_state_t    st_next;
   logic           ext_reg;
   logic           ext_next;
   logic           pass_reg;
   logic           pass_next;
   logic           err_reg;
   logic           err_next;
   logic [7:0]     secs_reg;
   logic [7:0]     secs_next;
   logic [7:0]     pat_reg;
   logic [7:0]     pat_next;
   logic [7:0]     exp_reg;
   logic [7:0]     exp_next;
   flsv_sideband_t sb_reg;
   flsv_sideband_t sb_next;
   logic           sof_reg;
   logic           sof_next;
   flsv_word_t     tx_reg;
   flsv_word_t     tx_next;
   logic [31:0]    rd_reg;
   logic [31:0]    rd_next;
   logic           tmr_load;
   logic           tmr_busy;
   logic           tmr_exp;
   flsv_word_t     rx_sel;
   logic [7:0]     req_secs;
   logic           start_req;

   assign wr_en   = i_psel && i_penable && i_pwrite;
   assign rd_en   = i_psel && i_penable && !i_pwrite;
   assign addr_ok = (i_paddr == FLSV_OFS_CTRL) || (i_paddr == FLSV_OFS_STATUS) ||
                    (i_paddr == FLSV_OFS_SIDEB) || (i_paddr == FLSV_OFS_RXSB);
   assign start_req = wr_en && (i_paddr == FLSV_OFS_CTRL) && i_pwdata[FLSV_CTRL_START];

   // Duration request, self test forces five seconds on the internal path
   always_comb
   begin
      req_secs = i_pwdata[FLSV_CTRL_SEC +: 8];
      if (i_pwdata[FLSV_CTRL_SELF])
         req_secs = FLSV_SELF_SEC;
      else if (req_secs < FLSV_DUR_FLOOR)
         req_secs = FLSV_DUR_FLOOR;
      else if (req_secs > FLSV_DUR_CEIL)
         req_secs = FLSV_DUR_CEIL;
   end

   assign tmr_load = start_req && (st_reg != FLSV_RUN);

   // Internal path returns transmit word directly, external uses optical receive
   always_comb
   begin
      if (ext_reg)
         rx_sel = i_rx_word;
      else
         rx_sel = tx_reg;
   end

   always_comb
   begin
      st_next   = st_reg;
      ext_next  = ext_reg;
      pass_next = pass_reg;
      err_next  = err_reg;
      secs_next = secs_reg;
      pat_next  = pat_reg;
      exp_next  = exp_reg;
      sb_next   = sb_reg;
      sof_next  = 1'b0;
      tx_next   = '0;
      case (st_reg)
         FLSV_IDLE, FLSV_DONE:
         begin
            if (tmr_load)
            begin
               st_next   = FLSV_RUN;
               ext_next  = i_pwdata[FLSV_CTRL_EXT] && !i_pwdata[FLSV_CTRL_SELF];
               secs_next = req_secs;
               pass_next = 1'b0;
               err_next  = 1'b0;
               pat_next  = FLSV_PATTERN_SEED;
               exp_next  = FLSV_PATTERN_SEED;
            end
         end
         FLSV_RUN:
         begin
            tx_next.valid = 1'b1;
            tx_next.data  = pat_reg;
            pat_next      = pat_reg + 8'h1;
            if (rx_sel.valid && !rx_sel.sof)
            begin
               if (rx_sel.data != exp_reg)
                  err_next = 1'b1;
               exp_next = rx_sel.data + 8'h1;
            end
            if (tmr_exp)
            begin
               st_next   = FLSV_DONE;
               pass_next = !err_next;
            end
         end
         default:
            st_next = FLSV_IDLE;
      endcase
      if (wr_en && (i_paddr == FLSV_OFS_CTRL) && i_pwdata[FLSV_CTRL_SOF])
         sof_next = 1'b1;
      if (sof_reg && (st_reg != FLSV_RUN))
      begin
         tx_next.valid = 1'b1;
         tx_next.sof   = 1'b1;
      end
      if (wr_en && (i_paddr == FLSV_OFS_SIDEB))
         sb_next = flsv_sideband_t'(i_pwdata[3:0]);
   end

   always_comb
   begin
      rd_next = 32'h0;
      if (i_paddr == FLSV_OFS_CTRL)
         rd_next = {16'h0, secs_reg, 6'h0, ext_reg, 1'b0};
      else if (i_paddr == FLSV_OFS_STATUS)
         rd_next = {28'h0, err_reg, pass_reg, st_reg == FLSV_DONE, st_reg == FLSV_RUN};
      else if (i_paddr == FLSV_OFS_SIDEB)
         rd_next = {28'h0, sb_reg};
      else if (i_paddr == FLSV_OFS_RXSB)
         rd_next = {28'h0, i_rx_sideband};
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_reg   <= FLSV_IDLE;
         ext_reg  <= 1'b0;
         pass_reg <= 1'b0;
         err_reg  <= 1'b0;
         secs_reg <= 8'h0;
         pat_reg  <= 8'h0;
         exp_reg  <= 8'h0;
         sb_reg   <= FLSV_SB_RESET;
         sof_reg  <= 1'b0;
         tx_reg   <= '0;
         rd_reg   <= 32'h0;
      end
      else
      begin
         st_reg   <= st_next;
         ext_reg  <= ext_next;
         pass_reg <= pass_next;
         err_reg  <= err_next;
         secs_reg <= secs_next;
         pat_reg  <= pat_next;
         exp_reg  <= exp_next;
         sb_reg   <= sb_next;
         sof_reg  <= sof_next | (sof_reg && (st_reg == FLSV_RUN));
         tx_reg   <= tx_next;
         if (i_psel && !i_penable)
            rd_reg <= rd_next;
      end
   end

   flsv_sec_timer #(
      .SEC_CYC (SEC_CYC)
   ) u_timer (
      .i_clk    (i_clk),
      .i_rstn   (i_rstn),
      .i_load   (tmr_load),
      .i_secs   (req_secs),
      .o_busy   (tmr_busy),
      .o_expire (tmr_exp)
   );

   assign o_prdata      = rd_en ? rd_reg : 32'h0;
   assign o_pready      = 1'b1;
   assign o_pslverr     = i_psel && i_penable && !addr_ok;
   assign o_tx_word     = tx_reg;
   assign o_tx_sideband = sb_reg;
   assign o_int_loop    = (st_reg == FLSV_RUN) && !ext_reg;
   assign o_check_busy  = tmr_busy;

   a_sideband_reset: assert property (@(posedge i_clk)
      $rose(i_rstn) |-> o_tx_sideband == 4'h0) else $error("sideband not zero");
   a_sideband_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_en && i_paddr == FLSV_OFS_SIDEB |=> o_tx_sideband == $past(i_pwdata[3:0]))
      else $error("sideband write lost");
   a_sideband_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !(wr_en && i_paddr == FLSV_OFS_SIDEB) |=> $stable(o_tx_sideband))
      else $error("sideband changed");
   a_sideband_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_en && i_paddr == FLSV_OFS_SIDEB |-> o_prdata[3:0] == o_tx_sideband)
      else $error("sideband readback wrong");
   a_dur_bounds: assert property (@(posedge i_clk) disable iff (!i_rstn)
      st_reg == FLSV_RUN |-> secs_reg >= FLSV_DUR_FLOOR && secs_reg <= FLSV_DUR_CEIL)
      else $error("duration out of bounds");
   a_self_five: assert property (@(posedge i_clk) disable iff (!i_rstn)
      tmr_load && i_pwdata[FLSV_CTRL_SELF] |=> secs_reg == 8'h05 && !ext_reg)
      else $error("self test not five seconds internal");
   a_int_path: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_int_loop |-> !err_reg) else $error("internal path saw an error");
   a_ext_path: assert property (@(posedge i_clk) disable iff (!i_rstn)
      st_reg == FLSV_RUN && ext_reg && i_rx_word.valid && !i_rx_word.sof
      && i_rx_word.data != exp_reg |=> err_reg)
      else $error("external path error missed");
   a_sof_send: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_en && i_paddr == FLSV_OFS_CTRL && i_pwdata[FLSV_CTRL_SOF] && st_reg != FLSV_RUN
      && !tmr_load |-> ##2 o_tx_word.sof) else $error("sync marker not sent");
   a_end_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
      st_reg == FLSV_RUN && tmr_exp |=> st_reg == FLSV_DONE && pass_reg == !err_reg)
      else $error("pass flag wrong");
   c_run_int: cover property (@(posedge i_clk) disable iff (!i_rstn) o_int_loop);
   c_run_ext: cover property (@(posedge i_clk) disable iff (!i_rstn)
      st_reg == FLSV_RUN && ext_reg);
   c_done: cover property (@(posedge i_clk) disable iff (!i_rstn) st_reg == FLSV_DONE);
   c_sof: cover property (@(posedge i_clk) disable iff (!i_rstn) o_tx_word.sof);
endmodule : flsv_top

/* flsv_pkg.sv */
// Package with constants and types for the fiber link sideband and verify block
// What this block does
// - Internal check loops transmit data to receive inside, bypassing optical ports.
// - External check uses optical ports; far side fits an optical short first.
// - Check lasts programmed seconds, clamped between duration floor and ceiling.
// - Self test runs an internal path check for five seconds.
// - On command a start-of-frame sync marker is sent over the link.
// - Four sideband bits a, b, direction, not-ready are carried unchanged.
// - All four sideband bits are zero after reset.
// - Software reads back the four sideband bits being transmitted.
package flsv_pkg;
   localparam logic [11:0] FLSV_OFS_CTRL   = 12'h000;
   localparam logic [11:0] FLSV_OFS_STATUS = 12'h004;
   localparam logic [11:0] FLSV_OFS_SIDEB  = 12'h008;
   localparam logic [11:0] FLSV_OFS_RXSB   = 12'h00c;
   localparam int          FLSV_CTRL_START = 0;
   localparam int          FLSV_CTRL_EXT   = 1;
   localparam int          FLSV_CTRL_SELF  = 2;
   localparam int          FLSV_CTRL_SOF   = 3;
   localparam int          FLSV_CTRL_SEC   = 8;
   localparam logic [7:0]  FLSV_DUR_FLOOR  = 8'h01;
   localparam logic [7:0]  FLSV_DUR_CEIL   = 8'h3c;
   localparam logic [7:0]  FLSV_SELF_SEC   = 8'h05;
   localparam int          FLSV_CLK_HZ     = 100000000;
   localparam int          FLSV_SEC_CYC    = FLSV_CLK_HZ;
   localparam logic [3:0]  FLSV_SB_RESET   = 4'h0;
   localparam logic [7:0]  FLSV_PATTERN_SEED = 8'h01;

   typedef struct packed {
      logic nrdy;
      logic dir;
      logic user_sideband_bit_b;
      logic user_sideband_bit_a;
   } flsv_sideband_t;

   typedef struct packed {
      logic       sof;
      logic [7:0] data;
      logic       valid;
   } flsv_word_t;

   typedef enum logic [1:0] {
      FLSV_IDLE = 2'b00,
      FLSV_RUN  = 2'b01,
      FLSV_DONE = 2'b10
   } flsv_state_t;
endpackage : flsv_pkg

/* flsv_sec_timer.sv */
// Seconds timer that counts down a programmed duration
module flsv_sec_timer #(
   parameter int SEC_CYC = 100000000
) (
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_load,
   input  wire logic [7:0] i_secs,
   output logic            o_busy,
   output logic            o_expire
);
   import flsv_pkg::*;
   logic [31:0] cyc_reg;
   logic [31:0] cyc_next;
   logic [7:0]  sec_reg;
   logic [7:0]  sec_next;
   logic        busy_reg;
   logic        busy_next;
   logic        exp_reg;
   logic        exp_next;

   always_comb
   begin
      cyc_next  = cyc_reg;
      sec_next  = sec_reg;
      busy_next = busy_reg;
      exp_next  = 1'b0;
      if (i_load)
      begin
         cyc_next  = 32'(SEC_CYC - 1);
         sec_next  = i_secs;
         busy_next = 1'b1;
      end
      else if (busy_reg)
      begin
         if (cyc_reg != 32'h0)
            cyc_next = cyc_reg - 32'h1;
         else if (sec_reg > 8'h1)
         begin
            sec_next = sec_reg - 8'h1;
            cyc_next = 32'(SEC_CYC - 1);
         end
         else
         begin
            busy_next = 1'b0;
            exp_next  = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cyc_reg  <= 32'h0;
         sec_reg  <= 8'h0;
         busy_reg <= 1'b0;
         exp_reg  <= 1'b0;
      end
      else
      begin
         cyc_reg  <= cyc_next;
         sec_reg  <= sec_next;
         busy_reg <= busy_next;
         exp_reg  <= exp_next;
      end
   end

   assign o_busy   = busy_reg;
   assign o_expire = exp_reg;
endmodule : flsv_sec_timer

/* flsv_remote.sv */
// Far link end model: an optical short, or an open receive line
module flsv_remote (
   input  wire logic                     i_clk,
   input  wire logic                     i_rstn,
   input  wire flsv_pkg::flsv_word_t     i_tx_word,
   input  wire flsv_pkg::flsv_sideband_t i_tx_sideband,
   input  wire logic                     i_short,
   input  wire logic                     i_corrupt,
   output flsv_pkg::flsv_word_t          o_rx_word,
   output flsv_pkg::flsv_sideband_t      o_rx_sideband
);
   timeunit 1ns;
   timeprecision 1ps;
   import flsv_pkg::*;
   logic [13:0] open_reg;
   // Open line shows a pattern that changes each cycle
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         open_reg <= 14'h0a5a;
      else
         open_reg <= ~open_reg;
   end
   always_comb
   begin
      if (i_short)
      begin
         o_rx_word = i_tx_word;
         o_rx_word.data[0] = i_tx_word.data[0] ^ i_corrupt;
         o_rx_sideband = i_tx_sideband;
      end
      else
      begin
         o_rx_word = flsv_word_t'(open_reg[9:0]);
         o_rx_sideband = flsv_sideband_t'(open_reg[13:10]);
      end
   end
endmodule : flsv_remote

/* testbench.sv */
// Self-checking bench for the link sideband and verify block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import flsv_pkg::*;
   localparam int SEC = 20;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, int_loop, busy;
   logic short_path = 1'b0, corrupt = 1'b0;
   flsv_word_t tx_word, rx_word;
   flsv_sideband_t tx_sb, rx_sb;
   int err_count = 0, checks = 0;

   always #5 i_clk = ~i_clk;

   flsv_top #(.SEC_CYC(SEC)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_tx_word(tx_word),
      .o_tx_sideband(tx_sb), .i_rx_word(rx_word), .i_rx_sideband(rx_sb),
      .o_int_loop(int_loop), .o_check_busy(busy));
   flsv_remote far (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx_word(tx_word),
      .i_tx_sideband(tx_sb), .i_short(short_path), .i_corrupt(corrupt),
      .o_rx_word(rx_word), .o_rx_sideband(rx_sb));

   task test_done;
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task chk_len(input int got, input int exp);
      checks++;
      if (got < exp - 3 || got > exp + 3)
      begin
         err_count++;
         $display("unexpected at %0t: run of %0d cycles, want %0d", $time, got, exp);
      end
   endtask : chk_len

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1)
         @(posedge i_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task t_reset;
      apb(1'b0, FLSV_OFS_SIDEB, 32'h0);
      chk(rd, 32'h0);
      chk(32'(tx_sb), 32'h0);
      chk(32'(busy), 32'h0);
   endtask : t_reset

   task t_sideband;
      short_path <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, FLSV_OFS_SIDEB, 32'h1 << i);
         @(negedge i_clk);
         chk(32'(tx_sb), 32'h1 << i);
         apb(1'b0, FLSV_OFS_SIDEB, 32'h0);
         chk(rd, 32'h1 << i);
         apb(1'b0, FLSV_OFS_RXSB, 32'h0);
         chk(rd, 32'h1 << i);
      end
      apb(1'b0, 12'h010, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
   endtask : t_sideband

   task t_sof;
      int seen;
      seen = 0;
      apb(1'b1, FLSV_OFS_CTRL, 32'h1 << FLSV_CTRL_SOF);
      repeat (6)
      begin
         @(negedge i_clk);
         if (tx_word.sof === 1'b1 && tx_word.valid === 1'b1)
            seen++;
      end
      chk(32'(seen), 32'h1);
   endtask : t_sof

   task t_check(input logic [31:0] ctrl, input int secs, input logic ext, input logic pass);
      int n;
      n = 0;
      @(posedge i_clk);
      short_path <= ext;
      corrupt <= ~pass;
      apb(1'b1, FLSV_OFS_CTRL, ctrl);
      while (busy !== 1'b1 && n < 5)
      begin
         @(negedge i_clk);
         n++;
      end
      chk(32'(int_loop), 32'(!ext));
      n = 0;
      while (busy === 1'b1 && n < 2000)
      begin
         @(negedge i_clk);
         n++;
      end
      chk_len(n, secs * SEC);
      apb(1'b0, FLSV_OFS_STATUS, 32'h0);
      chk(rd, {28'h0, ~pass, pass, 2'b10});
   endtask : t_check

   // Start and sync marker while running: start ignored, marker sent after the run
   task t_defer;
      int seen, early;
      seen = 0;
      early = 0;
      apb(1'b1, FLSV_OFS_CTRL, 32'h0000_0101);
      apb(1'b1, FLSV_OFS_CTRL, 32'h0000_0209);
      repeat (40)
      begin
         @(negedge i_clk);
         if (tx_word.sof === 1'b1 && tx_word.valid === 1'b1)
         begin
            seen++;
            if (busy !== 1'b0)
               early++;
         end
      end
      chk(32'(seen), 32'h1);
      chk(32'(early), 32'h0);
      apb(1'b0, FLSV_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0100);
   endtask : t_defer

   // Reset in the middle of a run with all sideband bits set
   task t_midreset;
      apb(1'b1, FLSV_OFS_SIDEB, 32'h0000_000f);
      apb(1'b1, FLSV_OFS_CTRL, 32'h0000_0101);
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(negedge i_clk);
      chk(32'(tx_sb), 32'h0);
      chk(32'(busy), 32'h0);
      chk(32'(tx_word), 32'h0);
      apb(1'b0, FLSV_OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      t_reset();
   endtask : t_midreset

   initial
   begin
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_reset();
      t_sideband();
      t_sof();
      t_check(32'h0000_0001, 1, 1'b0, 1'b1);
      t_check(32'h0000_0203, 2, 1'b1, 1'b1);
      t_check(32'h0000_0203, 2, 1'b1, 1'b0);
      t_check(32'h0000_ff01, 60, 1'b0, 1'b1);
      t_check(32'h0000_0107, 5, 1'b0, 1'b1);
      t_defer();
      t_midreset();
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      test_done();
   end
endmodule : testbench
